// ===== common/modem_pkg.sv
// Purpose: shared constants of the modem control and status block
// Assumes: eight-bit register port, three address bits
// Notes:   offsets index the register port directly

package modem_pkg;

    // register port
    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;
    localparam int DIV_W  = 16;

    // register offsets
    localparam logic [2:0] OFF_DIV_LOW      = 3'h0;
    localparam logic [2:0] OFF_DIV_HIGH     = 3'h1;
    localparam logic [2:0] OFF_INT_ENABLE   = 3'h2;
    localparam logic [2:0] OFF_INT_STATUS   = 3'h3;
    localparam logic [2:0] OFF_MODEM_CTRL   = 3'h4;
    localparam logic [2:0] OFF_MODEM_STATUS = 3'h6;

    // modem control fields
    localparam int MCR_TERM_READY = 0;
    localparam int MCR_REQ_SEND   = 1;
    localparam int MCR_OUT_A      = 2;
    localparam int MCR_OUT_B      = 3;
    localparam int MCR_LOOP       = 4;

    // interrupt enable fields
    localparam int IER_MODEM = 3;

    // modem status fields
    localparam int MSR_RING_EDGE  = 2;
    localparam int MSR_CARRIER_CH = 3;
    localparam int MSR_RING       = 6;
    localparam int MSR_CARRIER    = 7;

    // writable bits and reset values
    localparam logic [7:0]  MCR_WRITE_MASK = 8'h1f;
    localparam logic [7:0]  IER_WRITE_MASK = 8'h0f;
    localparam logic [7:0]  MCR_RESET      = 8'h00;
    localparam logic [7:0]  IER_RESET      = 8'h00;
    localparam logic [7:0]  DIV_BYTE_RESET = 8'h00;
    localparam logic [7:0]  READ_IDLE      = 8'h00;

    // interrupt status codes
    localparam logic [7:0]  INT_NONE  = 8'h01;
    localparam logic [7:0]  INT_MODEM = 8'h00;

    // idle level of the active-low pins
    localparam logic        PIN_IDLE = 1'b1;

endpackage : modem_pkg

// ===== common/modem_if.sv
// Purpose: signals between the core and its divider and status tracker
// Assumes: all ends on sys_clk
// Notes:   flags are sticky until clearFlags

`timescale 1ns/1ps

interface modem_if #(
    parameter int DIV_W = modem_pkg::DIV_W
);
    logic [DIV_W-1:0] divisor;
    logic             baudLevel;
    logic             ringActive;
    logic             carrierActive;
    logic             ringEdgeFlag;
    logic             carrierChgFlag;
    logic             clearFlags;

    modport core (
        output divisor,
        output clearFlags,
        input  baudLevel,
        input  ringActive,
        input  carrierActive,
        input  ringEdgeFlag,
        input  carrierChgFlag
    );

    modport divider (
        input  divisor,
        output baudLevel
    );

    modport tracker (
        input  clearFlags,
        output ringActive,
        output carrierActive,
        output ringEdgeFlag,
        output carrierChgFlag
    );
endinterface : modem_if

// ===== design/baud_divider.sv
// Purpose: divides sys_clk by the programmed divisor
// Assumes: divisor stable while counting
// Notes:   divisor zero stops the output low

`timescale 1ns/1ps

module baud_divider #(
    parameter int DIV_W = modem_pkg::DIV_W
) (
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic reset,
    // divisor in, baud level out
    modem_if.divider  bd
);

    typedef struct packed {
        logic [DIV_W-1:0] count;
        logic             level;
    } div_s;

    div_s q;
    div_s d;
    logic [DIV_W-1:0] half;

    always_comb begin
        d    = q;
        half = (bd.divisor >> 1) + {{(DIV_W-1){1'b0}}, bd.divisor[0]};
        if (bd.divisor == '0) begin
            d.count = '0;
            d.level = 1'b0;
        end else begin
            if ((q.count + DIV_W'(1)) >= bd.divisor) begin
                d.count = '0;
            end else begin
                d.count = q.count + DIV_W'(1);
            end
            // one period every divisor clocks, high for the first half
            d.level = (d.count < half);
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign bd.baudLevel = q.level;

endmodule : baud_divider

// ===== design/modem_status_tracker.sv
// Purpose: synchronises ring and carrier pins and keeps change flags
// Assumes: pins idle high
// Notes:   a change in the clearing cycle still sets its flag

`timescale 1ns/1ps

module modem_status_tracker (
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic reset,
    // modem pins, active low
    input  wire logic ringInN,
    input  wire logic carrierInN,
    // status towards the core
    modem_if.tracker  st
);

    typedef struct packed {
        logic ringMeta;
        logic ringSync;
        logic ringLast;
        logic carMeta;
        logic carSync;
        logic carLast;
        logic ringEdge;
        logic carChg;
    } trk_s;

    trk_s q;
    trk_s d;
    logic ringRise;
    logic carToggle;

    always_comb begin
        d          = q;
        d.ringMeta = ringInN;
        d.ringSync = q.ringMeta;
        d.ringLast = q.ringSync;
        d.carMeta  = carrierInN;
        d.carSync  = q.carMeta;
        d.carLast  = q.carSync;
        ringRise   = q.ringSync & ~q.ringLast;
        carToggle  = q.carSync ^ q.carLast;
        d.ringEdge = ringRise | (q.ringEdge & ~st.clearFlags);
        d.carChg   = carToggle | (q.carChg & ~st.clearFlags);
    end

    // pins reset to idle so release gives no false edge
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            q <= '{ringMeta: modem_pkg::PIN_IDLE, ringSync: modem_pkg::PIN_IDLE,
                   ringLast: modem_pkg::PIN_IDLE, carMeta: modem_pkg::PIN_IDLE,
                   carSync: modem_pkg::PIN_IDLE, carLast: modem_pkg::PIN_IDLE,
                   ringEdge: 1'b0, carChg: 1'b0};
        end else begin
            q <= d;
        end
    end

    assign st.ringActive     = ~q.ringSync;
    assign st.carrierActive  = ~q.carSync;
    assign st.ringEdgeFlag   = q.ringEdge;
    assign st.carrierChgFlag = q.carChg;

endmodule : modem_status_tracker

// ===== design/modem_control_status.sv
// Purpose: modem control outputs, modem status, interrupt and baud clock
// Assumes: master reset pin is asynchronous to sys_clk
// Notes:   read data stand one cycle after the read strobe
//
// Operation
// - request-to-send pin low while control bit 1 is set.
// - master reset drives request-to-send high.
// - baud output runs at reference clock over the 16-bit divisor.
// - general output A low while control bit 2 is set.
// - master reset drives general output A high.
// - loopback holds general output A high.
// - general output B low while control bit 3 is set.
// - master reset drives general output B high.
// - loopback holds general output B high.
// - ring indicator condition reads in status bit 6.
// - status bit 2 set when ring input rose since last read.
// - ring rise with enable bit 3 raises an interrupt.
// - carrier detect condition reads in status bit 7.
// - status bit 3 set on any carrier change since last read.
// - carrier detect never affects receiving, only status and interrupt.
// - carrier change with modem interrupt enabled raises an interrupt.
// - terminal-ready pin low while control bit 0 set, else high.
// - master reset clears the whole modem control register.
// - interrupt output high while enabled condition pending, cleared on service.

`timescale 1ns/1ps

module modem_control_status #(
    parameter int DIV_W = modem_pkg::DIV_W
) (
    // clock and reset
    input  wire logic                          sys_clk,
    input  wire logic                          reset,

    // register port
    input  wire logic [modem_pkg::ADDR_W-1:0]  regAddr,
    input  wire logic [modem_pkg::DATA_W-1:0]  regWrData,
    input  wire logic                          regWrite,
    input  wire logic                          regRead,
    output logic      [modem_pkg::DATA_W-1:0]  regRdData,

    // master reset pin
    input  wire logic                          masterResetIn,

    // modem inputs, active low
    input  wire logic                          ringInN,
    input  wire logic                          carrierInN,

    // modem outputs, active low
    output logic                               dataTermReadyN,
    output logic                               reqToSendN,
    output logic                               generalOutputAN,
    output logic                               generalOutputBN,

    // baud clock and interrupt
    output logic                               baudClockOut,
    output logic                               interruptRequestOut
);

    if (DIV_W < 2 || DIV_W > 2 * modem_pkg::DATA_W) begin : g_check
        $error("DIV_W must lie between 2 and twice the data width");
    end

    typedef struct packed {
        logic                          mrMeta;
        logic                          mrSync;
        logic [modem_pkg::DATA_W-1:0]  modem_control_reg;
        logic [modem_pkg::DATA_W-1:0]  interrupt_enable_reg;
        logic [modem_pkg::DATA_W-1:0]  divLow;
        logic [modem_pkg::DATA_W-1:0]  divHigh;
        logic [modem_pkg::DATA_W-1:0]  rdData;
        logic                          dtrN;
        logic                          rtsN;
        logic                          outAN;
        logic                          outBN;
        logic                          irq;
    } core_s;

    core_s q;
    core_s d;

    modem_if #(.DIV_W(DIV_W)) link ();

    baud_divider #(.DIV_W(DIV_W)) u_divider (
        .sys_clk (sys_clk),
        .reset   (reset),
        .bd      (link.divider)
    );

    modem_status_tracker u_tracker (
        .sys_clk    (sys_clk),
        .reset      (reset),
        .ringInN    (ringInN),
        .carrierInN (carrierInN),
        .st         (link.tracker)
    );

    // true when a strobe addresses the given offset
    function automatic logic hits(
        input logic                          strobe,
        input logic [modem_pkg::ADDR_W-1:0]  addr,
        input logic [modem_pkg::ADDR_W-1:0]  off
    );
        hits = strobe && (addr == off);
    endfunction : hits

    // carrier change and ring edge share one modem status cause
    function automatic logic modemPending(
        input logic [modem_pkg::DATA_W-1:0]  interrupt_enable_reg,
        input logic                          ringEdge,
        input logic                          carChg
    );
        modemPending = interrupt_enable_reg[modem_pkg::IER_MODEM] & (ringEdge | carChg);
    endfunction : modemPending

    logic [modem_pkg::DATA_W-1:0] statusWord;
    logic                         pending;

    // status snapshot taken before the read clears the flags
    always_comb begin
        statusWord = '0;
        statusWord[modem_pkg::MSR_RING]       = link.ringActive;
        statusWord[modem_pkg::MSR_RING_EDGE]  = link.ringEdgeFlag;
        // carrier goes to status and interrupt only, no receive path
        statusWord[modem_pkg::MSR_CARRIER]    = link.carrierActive;
        statusWord[modem_pkg::MSR_CARRIER_CH] = link.carrierChgFlag;
    end

    assign pending = modemPending(q.interrupt_enable_reg, link.ringEdgeFlag, link.carrierChgFlag);

    always_comb begin
        d        = q;
        d.mrMeta = masterResetIn;
        d.mrSync = q.mrMeta;
        d.rdData = modem_pkg::READ_IDLE;

        // register writes
        if (regWrite) begin
            case (regAddr)
                modem_pkg::OFF_DIV_LOW: begin
                    d.divLow = regWrData;
                end
                modem_pkg::OFF_DIV_HIGH: begin
                    d.divHigh = regWrData;
                end
                modem_pkg::OFF_INT_ENABLE: begin
                    d.interrupt_enable_reg = regWrData & modem_pkg::IER_WRITE_MASK;
                end
                modem_pkg::OFF_MODEM_CTRL: begin
                    d.modem_control_reg = regWrData & modem_pkg::MCR_WRITE_MASK;
                end
                default: begin
                    d.modem_control_reg = q.modem_control_reg;
                end
            endcase
        end

        // register reads, unmapped offsets answer zero
        if (regRead) begin
            case (regAddr)
                modem_pkg::OFF_DIV_LOW: begin
                    d.rdData = q.divLow;
                end
                modem_pkg::OFF_DIV_HIGH: begin
                    d.rdData = q.divHigh;
                end
                modem_pkg::OFF_INT_ENABLE: begin
                    d.rdData = q.interrupt_enable_reg;
                end
                modem_pkg::OFF_INT_STATUS: begin
                    d.rdData = pending ? modem_pkg::INT_MODEM : modem_pkg::INT_NONE;
                end
                modem_pkg::OFF_MODEM_CTRL: begin
                    d.rdData = q.modem_control_reg;
                end
                modem_pkg::OFF_MODEM_STATUS: begin
                    d.rdData = statusWord;
                end
                default: begin
                    d.rdData = modem_pkg::READ_IDLE;
                end
            endcase
        end

        // master reset wins over a write in the same cycle
        if (q.mrSync) begin
            d.modem_control_reg = modem_pkg::MCR_RESET;
            d.interrupt_enable_reg = modem_pkg::IER_RESET;
        end

        // pins follow the next control value, so reset lands at once
        d.dtrN  = ~d.modem_control_reg[modem_pkg::MCR_TERM_READY];
        d.rtsN  = ~d.modem_control_reg[modem_pkg::MCR_REQ_SEND];
        d.outAN = ~(d.modem_control_reg[modem_pkg::MCR_OUT_A] & ~d.modem_control_reg[modem_pkg::MCR_LOOP]);
        d.outBN = ~(d.modem_control_reg[modem_pkg::MCR_OUT_B] & ~d.modem_control_reg[modem_pkg::MCR_LOOP]);

        // drops with the flag clear that a status read or reset causes
        d.irq = modemPending(d.interrupt_enable_reg, link.ringEdgeFlag, link.carrierChgFlag) &
                ~link.clearFlags;
    end

    // flags clear on a status read and on master reset
    assign link.clearFlags = hits(regRead, regAddr, modem_pkg::OFF_MODEM_STATUS)
                             | q.mrSync;

    assign link.divisor = DIV_W'({q.divHigh, q.divLow});

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            q <= '{mrMeta: 1'b0, mrSync: 1'b0,
                   modem_control_reg: modem_pkg::MCR_RESET, interrupt_enable_reg: modem_pkg::IER_RESET,
                   divLow: modem_pkg::DIV_BYTE_RESET,
                   divHigh: modem_pkg::DIV_BYTE_RESET,
                   rdData: modem_pkg::READ_IDLE,
                   dtrN: modem_pkg::PIN_IDLE, rtsN: modem_pkg::PIN_IDLE,
                   outAN: modem_pkg::PIN_IDLE, outBN: modem_pkg::PIN_IDLE,
                   irq: 1'b0};
        end else begin
            q <= d;
        end
    end

    assign regRdData           = q.rdData;
    assign dataTermReadyN      = q.dtrN;
    assign reqToSendN          = q.rtsN;
    assign generalOutputAN     = q.outAN;
    assign generalOutputBN     = q.outBN;
    assign baudClockOut        = link.baudLevel;
    assign interruptRequestOut = q.irq;

endmodule : modem_control_status

// ===== verif/modem_control_status_asserts.sv
// Purpose: port-level checks of modem_control_status
// Assumes: only the top ports are visible
// Notes:   control writes are judged only clear of master reset
`timescale 1ns/1ps
module modem_control_status_asserts #(
    parameter int DIV_W = 16
) (
    // clock and reset
    input wire logic       sys_clk,
    input wire logic       reset,
    // register port
    input wire logic [2:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic       regWrite,
    input wire logic       regRead,
    input wire logic [7:0] regRdData,
    // pins
    input wire logic       masterResetIn,
    input wire logic       ringInN,
    input wire logic       carrierInN,
    input wire logic       dataTermReadyN,
    input wire logic       reqToSendN,
    input wire logic       generalOutputAN,
    input wire logic       generalOutputBN,
    input wire logic       interruptRequestOut
);
    logic [1:0] mrHist_q;
    logic [1:0] pinPrev_q;
    logic [2:0] quiet_q;
    logic       wrOk;
    logic       rdStat;

    // a synchronised master reset still in flight beats a write
    assign wrOk = regWrite && regAddr == 3'h4 && mrHist_q == 2'h0 && !masterResetIn;
    assign rdStat = regRead && regAddr == 3'h6 && mrHist_q == 2'h0 && !masterResetIn;

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            mrHist_q  <= 2'h3;
            pinPrev_q <= 2'h3;
            quiet_q   <= 3'h0;
        end else begin
            mrHist_q  <= {mrHist_q[0], masterResetIn};
            pinPrev_q <= {ringInN, carrierInN};
            if ({ringInN, carrierInN} != pinPrev_q) begin
                quiet_q <= 3'h0;
            end else if (quiet_q != 3'h7) begin
                quiet_q <= quiet_q + 3'h1;
            end
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    term_ready_a: assert property (wrOk |=> dataTermReadyN == !$past(regWrData[0]))
        else $error("terminal ready pin does not follow control bit");
    req_send_a: assert property (wrOk |=> reqToSendN == !$past(regWrData[1]))
        else $error("request to send pin does not follow control bit");
    out_a_a: assert property (wrOk |=> generalOutputAN ==
        !($past(regWrData[2]) && !$past(regWrData[4])))
        else $error("general output A wrong");
    out_b_a: assert property (wrOk |=> generalOutputBN ==
        !($past(regWrData[3]) && !$past(regWrData[4])))
        else $error("general output B wrong");
    mr_outputs_a: assert property (masterResetIn [*3] |=>
        {dataTermReadyN, reqToSendN, generalOutputAN, generalOutputBN} == 4'hf)
        else $error("master reset left an output active");
    mr_irq_a: assert property (masterResetIn [*3] |=> !interruptRequestOut)
        else $error("master reset left the interrupt high");
    read_clears_a: assert property (rdStat && quiet_q == 3'h7 |=> ##1 !interruptRequestOut)
        else $error("status read did not clear the interrupt");
    status_pins_a: assert property (rdStat && quiet_q >= 3'h4 |=>
        regRdData[7:6] == {!$past(carrierInN), !$past(ringInN)})
        else $error("status pin bits wrong");

    cover property (wrOk && regWrData[4]);
    cover property ($rose(interruptRequestOut));
    cover property (rdStat && quiet_q == 3'h7 && interruptRequestOut);
endmodule : modem_control_status_asserts

bind modem_control_status modem_control_status_asserts #(.DIV_W(DIV_W)) u_asserts (
    .sys_clk(sys_clk), .reset(reset), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .masterResetIn(masterResetIn), .ringInN(ringInN), .carrierInN(carrierInN),
    .dataTermReadyN(dataTermReadyN), .reqToSendN(reqToSendN),
    .generalOutputAN(generalOutputAN), .generalOutputBN(generalOutputBN),
    .interruptRequestOut(interruptRequestOut)
);

// ===== verif/modem_line_model.sv
// Purpose: modem side of the control lines
// Assumes: pins idle high through pull-ups
// Notes:   ring only reaches a terminal that is ready
`timescale 1ns/1ps
module modem_line_model (
    // from the block
    input  wire logic dataTermReadyN,
    // towards the block
    output logic      ringInN,
    output logic      carrierInN
);
    logic ringReqN = 1'b1;
    logic carReqN  = 1'b1;

    assign ringInN    = ringReqN | dataTermReadyN;
    assign carrierInN = carReqN;

    task automatic drive(input logic r, input logic c);
        ringReqN <= r;
        carReqN  <= c;
    endtask : drive
endmodule : modem_line_model

// ===== verif/tb_modem_control_status.sv
// Purpose: self-checking bench of modem_control_status
// Assumes: modem side played by modem_line_model
// Notes:   expectations come from a small register model
`timescale 1ns/1ps
module tb_modem_control_status;
    logic        sys_clk;
    logic        reset;
    logic [2:0]  regAddr;
    logic [7:0]  regWrData;
    logic        regWrite;
    logic        regRead;
    logic [7:0]  regRdData;
    logic        masterResetIn;
    logic        ringInN;
    logic        carrierInN;
    logic        dataTermReadyN;
    logic        reqToSendN;
    logic        generalOutputAN;
    logic        generalOutputBN;
    logic        baudClockOut;
    logic        interruptRequestOut;
    int          fails;
    int          comparisons;
    int          cnt;
    int          n;
    logic [31:0] seed;
    logic [7:0]  modem_control_reg;
    logic [7:0]  interrupt_enable_reg;
    logic [7:0]  d;
    logic        ringF;
    logic        carF;
    logic [1:0]  steps [7];
    logic [15:0] divs [6];

    modem_control_status #(.DIV_W(16)) u_modem_control_status (
        .sys_clk(sys_clk), .reset(reset), .regAddr(regAddr), .regWrData(regWrData),
        .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
        .masterResetIn(masterResetIn), .ringInN(ringInN), .carrierInN(carrierInN),
        .dataTermReadyN(dataTermReadyN), .reqToSendN(reqToSendN),
        .generalOutputAN(generalOutputAN), .generalOutputBN(generalOutputBN),
        .baudClockOut(baudClockOut), .interruptRequestOut(interruptRequestOut)
    );
    modem_line_model u_modem_line_model (
        .dataTermReadyN(dataTermReadyN), .ringInN(ringInN), .carrierInN(carrierInN)
    );

    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    task automatic tally(input logic ok, input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (!ok) begin
            fails++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : tally

    task automatic chkReg(input logic [7:0] got, input logic [7:0] exp);
        tally(got === exp, {8'h00, got}, {8'h00, exp});
    endtask : chkReg

    task automatic chkCount(input int got, input int exp);
        tally(got == exp, 16'(got), 16'(exp));
    endtask : chkCount

    task automatic chkPins();
        logic [4:0] got;
        logic [4:0] exp;
        got = {dataTermReadyN, reqToSendN, generalOutputAN, generalOutputBN, interruptRequestOut};
        exp = {~modem_control_reg[0], ~modem_control_reg[1], ~(modem_control_reg[2] & ~modem_control_reg[4]), ~(modem_control_reg[3] & ~modem_control_reg[4]), interrupt_enable_reg[3] & (ringF | carF)};
        tally(got === exp, {11'h0, got}, {11'h0, exp});
    endtask : chkPins

    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge sys_clk);
        regWrite  <= 1'b1;
        regAddr   <= a;
        regWrData <= v;
        @(posedge sys_clk);
        regWrite <= 1'b0;
    endtask : wr

    task automatic rd(input logic [2:0] a, output logic [7:0] v);
        @(posedge sys_clk);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge sys_clk);
        regRead <= 1'b0;
        @(negedge sys_clk);
        v = regRdData;
    endtask : rd

    task automatic rdChk(input logic [2:0] a, input logic [7:0] exp);
        rd(a, d);
        chkReg(d, exp);
    endtask : rdChk

    task automatic rdStatus();
        rd(3'h6, d);
        chkReg(d, {~carrierInN, ~ringInN, 2'b00, carF, ringF, 2'b00});
        ringF = 1'b0;
        carF  = 1'b0;
    endtask : rdStatus

    // flags follow the pin as the modem really drives it, ring gated by ready
    task automatic setPins(input logic r, input logic c);
        if (ringInN === 1'b0 && (r | ~modem_control_reg[0])) ringF = 1'b1;
        if (carrierInN !== c) carF = 1'b1;
        @(posedge sys_clk);
        u_modem_line_model.drive(r, c);
        repeat (6) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask : setPins

    task automatic end_sim();
        $display("comparisons=%0d fails=%0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : end_sim

    initial begin
        repeat (60000) @(posedge sys_clk);
        fails++;
        end_sim();
    end

    initial begin
        {regAddr, regWrData, regWrite, regRead, masterResetIn} = '0;
        {fails, comparisons} = '0;
        {modem_control_reg, interrupt_enable_reg, ringF, carF} = '0;
        seed = 32'hc4842ead;
        steps = '{2'b01, 2'b11, 2'b10, 2'b11, 2'b10, 2'b00, 2'b11};
        divs = '{16'h0000, 16'h0001, 16'h0002, 16'h0003, 16'h0007, 16'h0102};
        reset = 1'b1;
        repeat (16) @(posedge sys_clk);
        reset <= 1'b0;
        @(negedge sys_clk);
        chkPins();
        for (int i = 0; i < 8; i++) begin
            rdChk(3'(i), (i == 3) ? 8'h01 : 8'h00);
        end
        $display("reset test done");

        for (int i = 0; i < 24; i++) begin
            d = 8'(rnd());
            wr(3'h4, d);
            modem_control_reg = d & 8'h1f;
            @(negedge sys_clk);
            chkPins();
            rdChk(3'h4, modem_control_reg);
        end
        wr(3'h3, 8'hff);
        wr(3'h5, 8'hff);
        rdChk(3'h3, 8'h01);
        rdChk(3'h5, 8'h00);
        $display("control test done");

        wr(3'h4, 8'h01);
        modem_control_reg = 8'h01;
        wr(3'h2, 8'hf8);
        interrupt_enable_reg = 8'h08;
        rdStatus();
        for (int i = 0; i < 7; i++) begin
            if (i == 4) begin
                wr(3'h2, 8'h00);
                interrupt_enable_reg = 8'h00;
            end
            setPins(steps[i][1], steps[i][0]);
            chkPins();
            if (interrupt_enable_reg[3]) rdChk(3'h3, (ringF | carF) ? 8'h00 : 8'h01);
            rdStatus();
            chkPins();
        end
        $display("status test done");

        wr(3'h2, 8'h08);
        interrupt_enable_reg = 8'h08;
        wr(3'h4, 8'h0f);
        modem_control_reg = 8'h0f;
        setPins(1'b1, 1'b0);
        chkPins();
        @(posedge sys_clk);
        masterResetIn <= 1'b1;
        repeat (4) @(posedge sys_clk);
        masterResetIn <= 1'b0;
        {modem_control_reg, interrupt_enable_reg, ringF, carF} = '0;
        @(negedge sys_clk);
        chkPins();
        repeat (3) @(posedge sys_clk);
        rdChk(3'h4, 8'h00);
        rdChk(3'h2, 8'h00);
        rdStatus();
        $display("master reset test done");

        // a full period count is phase independent: high time is ceil(n/2) per period
        for (int i = 0; i < 6; i++) begin
            n = int'(divs[i]);
            wr(3'h0, divs[i][7:0]);
            wr(3'h1, divs[i][15:8]);
            repeat (n + 4) @(posedge sys_clk);
            cnt = 0;
            for (int k = 0; k < 8 * ((n == 0) ? 1 : n); k++) begin
                @(negedge sys_clk);
                if (baudClockOut === 1'b1) cnt++;
            end
            chkCount(cnt, 8 * ((n + 1) / 2));
        end
        $display("baud test done");
        end_sim();
    end
endmodule : tb_modem_control_status
